// file: bench/testbench.sv
// self-checking bench: shift and copy runs driven over the register bus
`timescale 1ns/100ps
module testbench;
  import tslm_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h0;
  logic [7:0]  araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, m_rd, m_wr, irq;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp;
  logic [31:0] rdata, rd_val;
  logic [15:0] m_addr, m_wdata, m_rdata;
  logic [15:0] img [0:4] = '{16'h1234, 16'h5678, 16'h1122, 16'h3344, 16'h5566};
  int          n_errors = 0;
  int          num_checks = 0;

  always #20 mclk = ~mclk;

  tslm_table_unit dut_u (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_addr(m_addr), .mem_rd(m_rd), .mem_wr(m_wr), .mem_wdata(m_wdata),
    .mem_rdata(m_rdata), .irq(irq));

  tslm_mem_model mem_u (.mclk(mclk), .mem_addr(m_addr), .mem_rd(m_rd), .mem_wr(m_wr),
    .mem_wdata(m_wdata), .mem_rdata(m_rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ready and response sampled at the falling edge, stable until the rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok)
    begin
      @(negedge mclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      wr_resp = bresp;
      @(posedge mclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    r_ok = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok)
    begin
      @(negedge mclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      rd_val = rdata;
      rd_resp = rresp;
      @(posedge mclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // leaves the final flags word in rd_val
  task automatic run_op(input logic [2:0] op);
    int t;
    t = 0;
    // start runs the op already stored, so the op goes in one write earlier
    axi_wr(OFS_CTRL, {28'h0, op, 1'b0});
    axi_wr(OFS_CTRL, {28'h0, op, 1'b1});
    do
    begin
      axi_rd(OFS_FLAGS);
      t++;
    end
    while (rd_val[FLG_BUSY_BIT] !== 1'b0 && t < 500);
  endtask

  task automatic do_shift(input logic [2:0] op, input int len, input int n);
    logic [127:0] v;
    logic [127:0] w;
    logic         ovf;
    logic         last;
    v = '0;
    for (int i = 0; i < len; i++)
    begin
      mem_u.mem[16 + i] = img[i];
      v[16*i +: 16] = img[i];
    end
    mem_u.mem[16 + len] = 16'hbeef;
    ovf = (n > 16 * len);
    last = 1'b0;
    if (!ovf && n > 0) last = (op == OP_SHR) ? v[n - 1] : v[16 * len - n];
    w = (op == OP_SHR) ? (v >> n) : (v << n);
    axi_wr(OFS_LENGTH, 32'(len));
    axi_wr(OFS_ACC, 32'h10);
    axi_wr(OFS_OPERAND, 32'(((n / 64) % 8) * 256 + ((n / 8) % 8) * 16 + n % 8));
    run_op(op);
    check(rd_val, {29'h0, 1'b0, last, ovf});
    for (int i = 0; i < len; i++)
      check({16'h0, mem_u.mem[16 + i]}, {16'h0, w[16*i +: 16]});
    check({16'h0, mem_u.mem[16 + len]}, 32'hbeef);
  endtask

  task automatic do_copy(input logic [2:0] op, input logic [15:0] pat);
    logic [15:0] e;
    for (int i = 0; i < 2; i++)
    begin
      mem_u.mem[16 + i] = img[i];
      mem_u.mem[64 + i] = 16'h0;
    end
    mem_u.mem[66] = 16'hbeef;
    axi_wr(OFS_LENGTH, 32'h2);
    axi_wr(OFS_ACC, 32'h10);
    axi_wr(OFS_PATTERN, {16'h0, pat});
    axi_wr(OFS_OPERAND, 32'h40);
    run_op(op);
    for (int i = 0; i < 2; i++)
    begin
      e = (op == OP_AND) ? (img[i] & pat) : (op == OP_OR) ? (img[i] | pat) : (img[i] ^ pat);
      check({16'h0, mem_u.mem[64 + i]}, {16'h0, e});
    end
    check({16'h0, mem_u.mem[66]}, 32'hbeef);
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    finish_test;
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    axi_rd(OFS_IRQ_EN);
    check(rd_val, 32'h0);
    axi_rd(8'h24);
    check({rd_val[29:0], rd_resp}, {30'h0, RESP_SLVERR});
    axi_wr(8'h24, 32'h1);
    check({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    axi_wr(OFS_IRQ_EN, 32'h3);
    do_shift(OP_SHR, 5, 12);
    @(negedge mclk);
    check({31'h0, irq}, 32'h1);
    axi_rd(OFS_IRQ_STS);
    check(rd_val, 32'h1);
    axi_wr(OFS_IRQ_CLR, 32'h1);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    do_shift(OP_SHL, 3, 18);
    do_shift(OP_SHR, 2, 31);
    do_shift(OP_SHL, 2, 32);
    do_shift(OP_SHR, 2, 33);
    axi_rd(OFS_IRQ_STS);
    check(rd_val, 32'h3);
    axi_wr(OFS_IRQ_EN, 32'h0);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    axi_wr(OFS_IRQ_CLR, 32'h3);
    do_shift(OP_SHL, 3, 0);
    do_copy(OP_AND, 16'h6666);
    do_copy(OP_OR, 16'h8888);
    do_copy(OP_XOR, 16'h3333);
    // unused op code: start is ignored, no done event
    axi_wr(OFS_IRQ_CLR, 32'h3);
    run_op(3'h5);
    check(rd_val, 32'h0);
    axi_rd(OFS_IRQ_STS);
    check(rd_val, 32'h0);
    finish_test;
  end
endmodule // testbench

// file: bench/tslm_mem_model.sv
// word memory model behind the table unit
`timescale 1ns/100ps
module tslm_mem_model
(
  // clock
  input  wire logic        mclk,
  // memory port
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [0:255];

  // churn outside the valid cycle so a late sample never looks right
  always @(posedge mclk)
  begin
    if (mem_rd)
      mem_rdata <= mem[mem_addr[7:0]];
    else
      mem_rdata <= ~mem_rdata;
  end

  // plain always so the bench may preload words between runs
  always @(posedge mclk)
  begin
    if (mem_wr)
      mem[mem_addr[7:0]] <= mem_wdata;
  end
endmodule // tslm_mem_model

// file: bench/tslm_table_unit_chk.sv
// port assertions for the table unit
`timescale 1ns/100ps
module tslm_table_unit_chk
  import tslm_pkg::*;
#(
  parameter int unsigned AXI_AW = 8
)
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst,
  // register bus
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // memory and interrupt
  input wire logic [15:0]       mem_addr,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic [WORD_W-1:0] mem_wdata,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic              irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_strobe_excl: assert property (!(mem_rd && mem_wr))
    else $error("memory read and write together");
  a_rd_pulse: assert property (mem_rd |=> !mem_rd)
    else $error("read strobe longer than one cycle");
  a_wr_after_data: assert property (mem_wr |-> !mem_rd && !$past(mem_rd))
    else $error("write before read data could arrive");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_cause: assert property ($rose(s_axi_bvalid) |->
      $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready, 2))
    else $error("write response without request");
  a_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_reset_quiet: assert property ($past(rst) |-> !mem_rd && !mem_wr && !irq && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule // tslm_table_unit_chk

bind tslm_table_unit tslm_table_unit_chk #(.AXI_AW(AXI_AW)) chk_u (
  .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .irq);

// file: rtl/tslm_pkg.sv
// constants and types for the table shift / logical copy unit
package tslm_pkg;

  // table word and parameter widths
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LEN_W  = 8;
  localparam int unsigned CNT_W  = 12;
  localparam int unsigned IDX_W  = 11;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_LENGTH  = 8'h04;
  localparam logic [7:0] OFS_ACC     = 8'h08;
  localparam logic [7:0] OFS_OPERAND = 8'h0c;
  localparam logic [7:0] OFS_PATTERN = 8'h10;
  localparam logic [7:0] OFS_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_IRQ_STS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h20;

  // field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_OP_LSB    = 1;
  localparam int unsigned FLG_OVF_BIT    = 0;
  localparam int unsigned FLG_LAST_BIT   = 1;
  localparam int unsigned FLG_BUSY_BIT   = 2;
  localparam int unsigned IRQ_DONE_BIT   = 0;
  localparam int unsigned IRQ_OVF_BIT    = 1;

  // operation codes in the control register
  localparam logic [2:0] OP_SHL = 3'h0;
  localparam logic [2:0] OP_SHR = 3'h1;
  localparam logic [2:0] OP_AND = 3'h2;
  localparam logic [2:0] OP_OR  = 3'h3;
  localparam logic [2:0] OP_XOR = 3'h4;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_LEN  = 8'h00;
  localparam logic [2:0]  RST_OP   = 3'h0;
  localparam logic [1:0]  RST_IRQ  = 2'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE, S_LB, S_LB_WAIT, S_LB_CAP, S_ISSUE, S_LO_WAIT, S_LO_CAP,
    S_HI_WAIT, S_HI_CAP, S_STEP, S_CP_ISS, S_CP_WAIT, S_CP_CAP, S_CP_STEP, S_DONE
  } tslm_state_e;

endpackage

// file: rtl/tslm_table_unit.sv
// table shift and logical table copy unit with axi4-lite registers
//
// Notes on behaviour
// - shifted bits cross into neighbouring words
// - table ends drop bits, insert zeros
// - table length from stack level, 0..ff
// - source start address from accumulator, hex
// - shift operand read as octal bit count
// - words are sixteen bits, positions 0..17 octal
// - overflow flag when count exceeds table bits
// - last-bit-out flag when final dropped bit one
// - flags held only until next use
// - right shift: top word most significant
// - copy combines words with and/or/xor
// - copy destination from operand, same length
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps

module tslm_table_unit
  import tslm_pkg::*;
#(
  parameter int unsigned AXI_AW = 8
)
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // axi4-lite write address
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read address
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // axi4-lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // word memory, read data valid the cycle after mem_rd
  output logic [15:0]              mem_addr,
  output logic                     mem_rd,
  output logic                     mem_wr,
  output logic [WORD_W-1:0]        mem_wdata,
  input  wire logic [WORD_W-1:0]   mem_rdata,
  // interrupt
  output logic                     irq
);

  function automatic logic [15:0] strb16(input logic [15:0] old_v,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    strb16 = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
  endfunction

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    is_mapped = (a[7:0] == OFS_CTRL) || (a[7:0] == OFS_LENGTH) || (a[7:0] == OFS_ACC) ||
                (a[7:0] == OFS_OPERAND) || (a[7:0] == OFS_PATTERN) ||
                (a[7:0] == OFS_FLAGS) || (a[7:0] == OFS_IRQ_STS) ||
                (a[7:0] == OFS_IRQ_CLR) || (a[7:0] == OFS_IRQ_EN);
  endfunction

  // packed octal digits, one per nibble; the top bit of each nibble is ignored
  function automatic logic [CNT_W-1:0] oct2bin(input logic [15:0] v);
    oct2bin = {v[14:12], v[10:8], v[6:4], v[2:0]};
  endfunction

  function automatic logic in_tab(input logic signed [IDX_W-1:0] x,
                                  input logic [LEN_W-1:0]        l);
    in_tab = (x >= 0) && (x < $signed({3'b000, l}));
  endfunction

  // software registers
  logic [LEN_W-1:0]  len_reg;
  logic [15:0]       acc_reg;
  logic [15:0]       opnd_reg;
  logic [15:0]       pat_reg;
  logic [2:0]        op_reg;
  logic              ovf_reg;
  logic              last_reg;
  logic [1:0]        irq_sts_reg;
  logic [1:0]        irq_en_reg;

  // bus slave state
  logic              aw_hold_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic              w_hold_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;

  // sequencer state
  tslm_state_e       state_reg;
  logic [2:0]        run_op_reg;
  logic [LEN_W-1:0]  run_len_reg;
  logic [15:0]       run_src_reg;
  logic [15:0]       run_dst_reg;
  logic [15:0]       run_pat_reg;
  logic [CNT_W-1:0]  run_cnt_reg;
  logic [LEN_W-1:0]  idx_reg;
  logic [WORD_W-1:0] lo_reg;
  logic [15:0]       mem_addr_reg;
  logic              mem_rd_reg;
  logic              mem_wr_reg;
  logic [WORD_W-1:0] mem_wdata_reg;

  logic              wr_go;
  logic [7:0]        wr_ofs;
  logic              start_req;
  logic              busy;
  logic              is_shift;
  logic              shr;
  logic [CNT_W-1:0]  cnt_new;
  logic [CNT_W-1:0]  total_new;
  logic [CNT_W-1:0]  total_run;
  logic [CNT_W-1:0]  lb_pos;
  logic signed [IDX_W-1:0] i_s;
  logic signed [IDX_W-1:0] q_s;
  logic signed [IDX_W-1:0] lo_idx;
  logic signed [IDX_W-1:0] hi_idx;
  logic [WORD_W-1:0] hi_word;
  logic [31:0]       pair_shr;
  logic [31:0]       pair_shl;
  logic [WORD_W-1:0] shift_word;
  logic [WORD_W-1:0] copy_word;
  logic              last_idx;
  logic              ev_done;
  logic              ev_ovf;
  logic [1:0]        irq_clr;

  assign wr_go     = aw_hold_reg && w_hold_reg;
  assign wr_ofs    = aw_addr_reg[7:0];
  assign busy      = (state_reg != S_IDLE);
  assign start_req = wr_go && (wr_ofs == OFS_CTRL) && w_strb_reg[0] &&
                     w_data_reg[CTRL_START_BIT] && !busy;
  assign irq_clr   = (wr_go && (wr_ofs == OFS_IRQ_CLR) && w_strb_reg[0]) ? w_data_reg[1:0] : 2'h0;

  // start operands come straight from the registers being latched
  assign is_shift  = (op_reg == OP_SHL) || (op_reg == OP_SHR);
  assign cnt_new   = oct2bin(opnd_reg);
  assign total_new = {len_reg, 4'h0};

  assign shr       = (run_op_reg == OP_SHR);
  assign total_run = {run_len_reg, 4'h0};
  assign lb_pos    = shr ? (run_cnt_reg - 12'h001) : (total_run - run_cnt_reg);
  assign i_s       = $signed({3'b000, idx_reg});
  assign q_s       = $signed({3'b000, run_cnt_reg[11:4]});
  assign lo_idx    = shr ? (i_s + q_s) : (i_s - q_s - 11'sd1);
  assign hi_idx    = lo_idx + 11'sd1;
  assign hi_word   = in_tab(hi_idx, run_len_reg) ? mem_rdata : RST_WORD;
  assign pair_shr  = {hi_word, lo_reg} >> run_cnt_reg[3:0];
  assign pair_shl  = {hi_word, lo_reg} << run_cnt_reg[3:0];
  assign shift_word = shr ? pair_shr[15:0] : pair_shl[31:16];
  assign last_idx  = shr ? (idx_reg == run_len_reg - 8'h01) : (idx_reg == 8'h00);

  always_comb
  begin
    case (run_op_reg)
      OP_AND:  copy_word = mem_rdata & run_pat_reg;
      OP_OR:   copy_word = mem_rdata | run_pat_reg;
      OP_XOR:  copy_word = mem_rdata ^ run_pat_reg;
      default: copy_word = mem_rdata;
    endcase
  end

  // axi4-lite write path: address and data taken independently
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // register writes; parameters are ignored while a run is busy
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      len_reg    <= RST_LEN;
      acc_reg    <= RST_WORD;
      opnd_reg   <= RST_WORD;
      pat_reg    <= RST_WORD;
      op_reg     <= RST_OP;
      irq_en_reg <= RST_IRQ;
    end
    else if (wr_go && !busy)
    begin
      case (wr_ofs)
        OFS_CTRL:    if (w_strb_reg[0]) op_reg <= w_data_reg[CTRL_OP_LSB +: 3];
        OFS_LENGTH:  if (w_strb_reg[0]) len_reg <= w_data_reg[7:0];
        OFS_ACC:     acc_reg <= strb16(acc_reg, w_data_reg, w_strb_reg);
        OFS_OPERAND: opnd_reg <= strb16(opnd_reg, w_data_reg, w_strb_reg);
        OFS_PATTERN: pat_reg <= strb16(pat_reg, w_data_reg, w_strb_reg);
        OFS_IRQ_EN:  if (w_strb_reg[0]) irq_en_reg <= w_data_reg[1:0];
        default:     ;
      endcase
    end
  end

  // axi4-lite read path, answer one cycle after the address is taken
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr[7:0])
        OFS_CTRL:    rdata_reg <= {28'h0000000, op_reg, 1'b0};
        OFS_LENGTH:  rdata_reg <= {24'h000000, len_reg};
        OFS_ACC:     rdata_reg <= {16'h0000, acc_reg};
        OFS_OPERAND: rdata_reg <= {16'h0000, opnd_reg};
        OFS_PATTERN: rdata_reg <= {16'h0000, pat_reg};
        OFS_FLAGS:   rdata_reg <= {29'h00000000, busy, last_reg, ovf_reg};
        OFS_IRQ_STS: rdata_reg <= {30'h00000000, irq_sts_reg};
        OFS_IRQ_EN:  rdata_reg <= {30'h00000000, irq_en_reg};
        default:     rdata_reg <= 32'h0000_0000;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // sticky interrupt status; a new event wins over a clear in the same cycle
  assign ev_done = (state_reg == S_DONE);
  assign ev_ovf  = ev_done && ovf_reg;
  assign irq     = |(irq_sts_reg & irq_en_reg);

  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_sts_reg <= RST_IRQ;
    else
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | {ev_ovf, ev_done};
  end

  // memory port from flops
  assign mem_addr  = mem_addr_reg;
  assign mem_rd    = mem_rd_reg;
  assign mem_wr    = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;

  // sequencer; right shift walks upward, left shift downward, so every
  // word is read before it is overwritten in place
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg     <= S_IDLE;
      run_op_reg    <= RST_OP;
      run_len_reg   <= RST_LEN;
      run_src_reg   <= RST_WORD;
      run_dst_reg   <= RST_WORD;
      run_pat_reg   <= RST_WORD;
      run_cnt_reg   <= '0;
      idx_reg       <= '0;
      lo_reg        <= RST_WORD;
      ovf_reg       <= 1'b0;
      last_reg      <= 1'b0;
      mem_addr_reg  <= RST_WORD;
      mem_rd_reg    <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_wdata_reg <= RST_WORD;
    end
    else
    begin
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      case (state_reg)
        S_IDLE:
          if (start_req && (is_shift || op_reg == OP_AND || op_reg == OP_OR ||
                            op_reg == OP_XOR))
          begin
            run_op_reg  <= op_reg;
            run_len_reg <= len_reg;
            run_src_reg <= acc_reg;
            run_dst_reg <= opnd_reg;
            run_pat_reg <= pat_reg;
            run_cnt_reg <= cnt_new;
            idx_reg     <= (op_reg == OP_SHL) ? (len_reg - 8'h01) : 8'h00;
            if (is_shift)
            begin
              ovf_reg  <= (cnt_new > total_new);
              last_reg <= 1'b0;
            end
            if (len_reg == 8'h00 || (is_shift && cnt_new == 12'h000))
              state_reg <= S_DONE;
            else if (!is_shift)
              state_reg <= S_CP_ISS;
            else if (cnt_new > total_new)
              state_reg <= S_ISSUE;
            else
              state_reg <= S_LB;
          end
        S_LB:
        begin
          mem_rd_reg   <= 1'b1;
          mem_addr_reg <= run_src_reg + {8'h00, lb_pos[11:4]};
          state_reg    <= S_LB_WAIT;
        end
        S_LB_WAIT:
          state_reg <= S_LB_CAP;
        S_LB_CAP:
        begin
          last_reg  <= mem_rdata[lb_pos[3:0]];
          state_reg <= S_ISSUE;
        end
        S_ISSUE:
        begin
          mem_rd_reg   <= in_tab(lo_idx, run_len_reg);
          mem_addr_reg <= run_src_reg + {5'h00, lo_idx};
          state_reg    <= S_LO_WAIT;
        end
        S_LO_WAIT:
          state_reg <= S_LO_CAP;
        S_LO_CAP:
        begin
          lo_reg       <= in_tab(lo_idx, run_len_reg) ? mem_rdata : RST_WORD;
          mem_rd_reg   <= in_tab(hi_idx, run_len_reg);
          mem_addr_reg <= run_src_reg + {5'h00, hi_idx};
          state_reg    <= S_HI_WAIT;
        end
        S_HI_WAIT:
          state_reg <= S_HI_CAP;
        S_HI_CAP:
        begin
          mem_wr_reg    <= 1'b1;
          mem_addr_reg  <= run_src_reg + {8'h00, idx_reg};
          mem_wdata_reg <= shift_word;
          state_reg     <= S_STEP;
        end
        S_STEP:
          if (last_idx)
            state_reg <= S_DONE;
          else
          begin
            idx_reg   <= shr ? (idx_reg + 8'h01) : (idx_reg - 8'h01);
            state_reg <= S_ISSUE;
          end
        S_CP_ISS:
        begin
          mem_rd_reg   <= 1'b1;
          mem_addr_reg <= run_src_reg + {8'h00, idx_reg};
          state_reg    <= S_CP_WAIT;
        end
        S_CP_WAIT:
          state_reg <= S_CP_CAP;
        S_CP_CAP:
        begin
          mem_wr_reg    <= 1'b1;
          mem_addr_reg  <= run_dst_reg + {8'h00, idx_reg};
          mem_wdata_reg <= copy_word;
          state_reg     <= S_CP_STEP;
        end
        S_CP_STEP:
          if (idx_reg == run_len_reg - 8'h01)
            state_reg <= S_DONE;
          else
          begin
            idx_reg   <= idx_reg + 8'h01;
            state_reg <= S_CP_ISS;
          end
        S_DONE:
          state_reg <= S_IDLE;
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // tslm_table_unit
